// ### pkg/mpd_params.svh
// Purpose: Constants for the move/push opcode decoder
// Assumes: Byte-wide instruction stream, one byte per accepted beat
// Notes: Clock counts are per form, register source / memory source
`ifndef MPD_PARAMS_SVH
`define MPD_PARAMS_SVH

// Opcode patterns
`define MPD_OP_TO_SEG 8'h8E
`define MPD_OP_FROM_SEG 8'h8C
`define MPD_OP_ESCAPE 8'h0F
`define MPD_OP_SX_BASE 7'h5F
`define MPD_OP_ZX_BASE 7'h5B
`define MPD_OP_PUSH_RM 8'hFF
`define MPD_PUSH_RM_FIELD 3'h6
`define MPD_OP_PUSH_REG_HI 5'h0A
`define MPD_MOD_REG 2'h3

// Clock counts: column A, column B
`define MPD_CLK_TO_SEG_A_REG 5'h02
`define MPD_CLK_TO_SEG_A_MEM 5'h05
`define MPD_CLK_TO_SEG_B_REG 5'h12
`define MPD_CLK_TO_SEG_B_MEM 5'h13
`define MPD_CLK_FROM_SEG 5'h02
`define MPD_CLK_EXT_REG 5'h03
`define MPD_CLK_EXT_MEM 5'h06
`define MPD_CLK_PUSH_RM 5'h05
`define MPD_CLK_PUSH_REG 5'h02

`endif

// ### pkg/mpd_pkg.sv
// Purpose: Types shared by the move/push opcode decoder
// Assumes: Included constants header defines the encodings
// Notes: Form codes are one-hot, except MPD_FORM_NONE which is zero
`default_nettype none
package mpd_pkg;

  // Recognised instruction forms
  typedef enum logic [6:0] {
    MPD_FORM_NONE = 7'h00,
    MPD_FORM_TO_SEG = 7'h01,
    MPD_FORM_FROM_SEG = 7'h02,
    MPD_FORM_SX = 7'h04,
    MPD_FORM_ZX = 7'h08,
    MPD_FORM_PUSH_RM = 7'h10,
    MPD_FORM_PUSH_REG = 7'h20,
    MPD_FORM_OTHER = 7'h40
  } mpd_form_t;

  // Decoded result handed to the execution side
  typedef struct packed {
    mpd_form_t form;
    logic [1:0] mod_field;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic src_word;
    logic mem_src;
    logic [4:0] clocks_a;
    logic [4:0] clocks_b;
  } mpd_result_t;

  // Passed-through sequence for other decode logic
  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic two_bytes;
  } mpd_pass_t;

endpackage
`default_nettype wire

// ### design/mpd_clock_table.sv
// Purpose: Clock count lookup for each decoded form
// Assumes: Form and source kind are already known
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "mpd_params.svh"

module mpd_clock_table
  import mpd_pkg::*;
(
  input wire mpd_pkg::mpd_form_t form_in,
  input wire logic mem_src_in,
  output logic [4:0] clocks_a_out,
  output logic [4:0] clocks_b_out
);
  import mpd_pkg::*;

  // Pick counts; forms outside this subset report zero
  always_comb begin
    clocks_a_out = 5'h00;
    clocks_b_out = 5'h00;
    case (form_in)
      MPD_FORM_TO_SEG: begin
        clocks_a_out = mem_src_in ? `MPD_CLK_TO_SEG_A_MEM
                                  : `MPD_CLK_TO_SEG_A_REG;
        clocks_b_out = mem_src_in ? `MPD_CLK_TO_SEG_B_MEM
                                  : `MPD_CLK_TO_SEG_B_REG;
      end
      MPD_FORM_FROM_SEG: begin
        clocks_a_out = `MPD_CLK_FROM_SEG;
        clocks_b_out = `MPD_CLK_FROM_SEG;
      end
      MPD_FORM_SX, MPD_FORM_ZX: begin
        clocks_a_out = mem_src_in ? `MPD_CLK_EXT_MEM
                                  : `MPD_CLK_EXT_REG;
        clocks_b_out = clocks_a_out;
      end
      MPD_FORM_PUSH_RM: begin
        clocks_a_out = `MPD_CLK_PUSH_RM;
        clocks_b_out = `MPD_CLK_PUSH_RM;
      end
      MPD_FORM_PUSH_REG: begin
        clocks_a_out = `MPD_CLK_PUSH_REG;
        clocks_b_out = `MPD_CLK_PUSH_REG;
      end
      default: begin
        clocks_a_out = 5'h00;
        clocks_b_out = 5'h00;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### design/mpd_decoder.sv
// Purpose: Byte-serial decoder for segment moves, extending moves, pushes
// Assumes: Fetch side presents one byte per valid/ready handshake
// Notes: Result and pass-through words are registered and hold; their valid flags are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "mpd_params.svh"

// Behaviour
// - Byte 8E plus addressing byte loads segment register from bits 5:3.
// - Segment load costs 2/5 clocks in one column, 18/19 in the other.
// - Byte 8C plus addressing byte stores segment register; 2 clocks both.
// - 0F then 1011111w plus addressing byte sign-extends; 3 reg, 6 mem.
// - 0F then 1011011w plus addressing byte zero-extends; 3 reg, 6 mem.
// - Byte FF with middle field 110 pushes register or memory in 5 clocks.
// - Single byte 01010rrr pushes register rrr in 2 clocks.
module mpd_decoder
  import mpd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [7:0] byte_in,
  input wire logic byte_valid_in,
  output logic byte_ready_out,
  output mpd_pkg::mpd_result_t result_out,
  output logic result_valid_out,
  output mpd_pkg::mpd_pass_t pass_out,
  output logic pass_valid_out
);
  import mpd_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_FIRST = 4'h1,
    ST_ESC = 4'h2,
    ST_MODRM = 4'h4,
    ST_HOLD = 4'h8
  } mpd_state_t;

  mpd_state_t state_r, state_nxt;
  mpd_form_t form_r, form_nxt;
  logic [7:0] b0_r, b0_nxt;
  logic [7:0] b1_r, b1_nxt;
  logic word_r, word_nxt;
  mpd_result_t result_r, result_nxt;
  logic result_valid_r, result_valid_nxt;
  mpd_pass_t pass_r, pass_nxt;
  logic pass_valid_r, pass_valid_nxt;
  logic take;
  logic [4:0] clk_a;
  logic [4:0] clk_b;
  mpd_form_t lookup_form;
  logic lookup_mem;

  // Addressing byte names memory unless mod is 11
  function automatic logic is_mem(input logic [7:0] modrm);
    is_mem = (modrm[7:6] != `MPD_MOD_REG);
  endfunction

  // Build a result word from a form and an addressing byte
  function automatic mpd_result_t pack_result(
    input mpd_form_t f, input logic [7:0] m, input logic w,
    input logic [4:0] ca, input logic [4:0] cb);
    mpd_result_t r;
    r = '0;
    r.form = f;
    r.mod_field = m[7:6];
    r.reg_field = m[5:3];
    r.rm_field = m[2:0];
    r.src_word = w;
    r.mem_src = is_mem(m);
    r.clocks_a = ca;
    r.clocks_b = cb;
    pack_result = r;
  endfunction

  // Ready whenever not stalled on completion; valid outputs last one cycle
  assign byte_ready_out = (state_r != ST_HOLD);
  assign take = byte_valid_in && byte_ready_out;
  assign result_out = result_r;
  assign result_valid_out = result_valid_r;
  assign pass_out = pass_r;
  assign pass_valid_out = pass_valid_r;

  // Clock counts for the form being completed this cycle
  assign lookup_form = (state_r == ST_FIRST) ? MPD_FORM_PUSH_REG : form_r;
  assign lookup_mem = is_mem(byte_in);

  mpd_clock_table u_clock_table (
    .form_in(lookup_form),
    .mem_src_in(lookup_mem),
    .clocks_a_out(clk_a),
    .clocks_b_out(clk_b)
  );

  // ----------------------------------------
  // Next-state decode
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    form_nxt = form_r;
    b0_nxt = b0_r;
    b1_nxt = b1_r;
    word_nxt = word_r;
    result_nxt = result_r;
    result_valid_nxt = 1'b0;
    pass_nxt = pass_r;
    pass_valid_nxt = 1'b0;
    case (state_r)
      ST_FIRST: begin
        if (take) begin
          b0_nxt = byte_in;
          word_nxt = 1'b0;
          if (byte_in == `MPD_OP_TO_SEG) begin
            form_nxt = MPD_FORM_TO_SEG;
            state_nxt = ST_MODRM;
          end else if (byte_in == `MPD_OP_FROM_SEG) begin
            form_nxt = MPD_FORM_FROM_SEG;
            state_nxt = ST_MODRM;
          end else if (byte_in == `MPD_OP_PUSH_RM) begin
            form_nxt = MPD_FORM_PUSH_RM;
            state_nxt = ST_MODRM;
          end else if (byte_in == `MPD_OP_ESCAPE) begin
            state_nxt = ST_ESC;
          end else if (byte_in[7:3] == `MPD_OP_PUSH_REG_HI) begin
            // Single byte form completes at once
            result_nxt = pack_result(MPD_FORM_PUSH_REG,
              {`MPD_MOD_REG, 3'h0, byte_in[2:0]}, 1'b1,
              clk_a, clk_b);
            result_valid_nxt = 1'b1;
            state_nxt = ST_HOLD;
          end else begin
            pass_nxt = '{byte0: byte_in, byte1: 8'h00,
                         two_bytes: 1'b0};
            pass_valid_nxt = 1'b1;
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_ESC: begin
        if (take) begin
          b1_nxt = byte_in;
          word_nxt = byte_in[0];
          if (byte_in[7:1] == `MPD_OP_SX_BASE) begin
            form_nxt = MPD_FORM_SX;
            state_nxt = ST_MODRM;
          end else if (byte_in[7:1] == `MPD_OP_ZX_BASE) begin
            form_nxt = MPD_FORM_ZX;
            state_nxt = ST_MODRM;
          end else begin
            pass_nxt = '{byte0: b0_r, byte1: byte_in,
                         two_bytes: 1'b1};
            pass_valid_nxt = 1'b1;
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          if (form_r == MPD_FORM_PUSH_RM &&
              byte_in[5:3] != `MPD_PUSH_RM_FIELD) begin
            // Other FF group members belong elsewhere
            pass_nxt = '{byte0: b0_r, byte1: byte_in,
                         two_bytes: 1'b1};
            pass_valid_nxt = 1'b1;
          end else begin
            result_nxt = pack_result(form_r, byte_in, word_r,
                                     clk_a, clk_b);
            result_valid_nxt = 1'b1;
          end
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // One idle cycle so each output pulse is seen alone
        state_nxt = ST_FIRST;
      end
      default: begin
        state_nxt = ST_FIRST;
      end
    endcase
  end

  // Register everything
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_r <= ST_FIRST;
      form_r <= MPD_FORM_NONE;
      b0_r <= 8'h00;
      b1_r <= 8'h00;
      word_r <= 1'b0;
      result_r <= '0;
      result_valid_r <= 1'b0;
      pass_r <= '0;
      pass_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      form_r <= form_nxt;
      b0_r <= b0_nxt;
      b1_r <= b1_nxt;
      word_r <= word_nxt;
      result_r <= result_nxt;
      result_valid_r <= result_valid_nxt;
      pass_r <= pass_nxt;
      pass_valid_r <= pass_valid_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_TO_SEG_DECODE: assert property (@(posedge mclk_in)
    disable iff (srst_in)
    (state_r == ST_MODRM && form_r == MPD_FORM_TO_SEG && take)
    |=> (result_valid_out && result_out.reg_field == $past(byte_in[5:3])))
    else $error("segment load not decoded");
  AST_TO_SEG_CLOCKS: assert property (@(posedge mclk_in)
    disable iff (srst_in)
    (result_valid_out && result_out.form == MPD_FORM_TO_SEG)
    |-> (result_out.mem_src ? (result_out.clocks_a == 5'h05 &&
         result_out.clocks_b == 5'h13) : (result_out.clocks_a == 5'h02 &&
         result_out.clocks_b == 5'h12)))
    else $error("segment load clocks wrong");
  AST_FROM_SEG: assert property (@(posedge mclk_in)
    disable iff (srst_in)
    (state_r == ST_FIRST && take && byte_in == 8'h8C) ##1
    (state_r == ST_MODRM && take) |=> (result_valid_out &&
    result_out.form == MPD_FORM_FROM_SEG && result_out.clocks_b == 5'h02))
    else $error("segment store wrong");
  AST_SIGN_EXT: assert property (@(posedge mclk_in)
    disable iff (srst_in)
    (result_valid_out && result_out.form == MPD_FORM_SX) |->
    (result_out.clocks_a == (result_out.mem_src ? 5'h06 : 5'h03)))
    else $error("sign extend clocks wrong");
  AST_ZERO_EXT: assert property (@(posedge mclk_in)
    disable iff (srst_in)
    (state_r == ST_ESC && take && byte_in[7:1] == 7'h5B) ##1
    (take) |=> (result_valid_out && result_out.form == MPD_FORM_ZX &&
    result_out.src_word == $past(b1_r[0])))
    else $error("zero extend not decoded");
  AST_PUSH_RM: assert property (@(posedge mclk_in)
    disable iff (srst_in)
    (result_valid_out && result_out.form == MPD_FORM_PUSH_RM) |->
    (result_out.reg_field == 3'h6 && result_out.clocks_a == 5'h05))
    else $error("push operand wrong");
  AST_PUSH_REG: assert property (@(posedge mclk_in)
    disable iff (srst_in)
    (state_r == ST_FIRST && take && byte_in[7:3] == 5'h0A) |=>
    (result_valid_out && result_out.rm_field == $past(byte_in[2:0]) &&
    result_out.clocks_a == 5'h02) ##1 !result_valid_out)
    else $error("short push wrong");
  AST_PASS_ON: assert property (@(posedge mclk_in)
    disable iff (srst_in)
    (state_r == ST_FIRST && take && byte_in == 8'h90) |=>
    (pass_valid_out && !result_valid_out && pass_out.byte0 == 8'h90))
    else $error("unknown byte not passed");

endmodule
`default_nettype wire

// ### testbench/mpd_fetch_model.sv
// Purpose: Instruction fetch stream model feeding the decoder
// Assumes: Bytes change at the falling edge of mclk_in
// Notes: Idle data lines carry the inverse of the last byte offered
`timescale 1ns/1ps
`default_nettype none
module mpd_fetch_model (
  input wire logic mclk_in,
  input wire logic byte_ready_in,
  output logic [7:0] byte_out,
  output logic byte_valid_out
);
  logic [7:0] last_byte;

  // ----------------------------------------
  // Offer and release
  // ----------------------------------------
  initial begin
    byte_out = 8'h00;
    byte_valid_out = 1'b0;
    last_byte = 8'h00;
  end

  // Withdraw; a stale copy would hide a decoder that samples late
  task automatic idle();
    @(negedge mclk_in);
    byte_valid_out = 1'b0;
    byte_out = ~last_byte;
  endtask

  // Offer after gap idle cycles, hold until an edge sees ready high
  task automatic send(input logic [7:0] b, input int gap);
    int i;
    for (i = 0; i < gap; i++) begin
      idle();
    end
    @(negedge mclk_in);
    byte_out = b;
    byte_valid_out = 1'b1;
    last_byte = b;
    // Ready moves only at rising edges, so reading it mid-cycle avoids
    // racing the edge that updates it; a hang is left to the watchdog
    while (byte_ready_in !== 1'b1) begin
      @(negedge mclk_in);
    end
    @(posedge mclk_in);
  endtask
endmodule
`default_nettype wire

// ### testbench/move_push_opcode_decode_tb.sv
// Purpose: Self-checking bench for the move/push opcode decoder
// Assumes: One byte per handshake, result one cycle after last byte
// Notes: Expected fields are worked out from the encodings here
`timescale 1ns/1ps
`default_nettype none
module move_push_opcode_decode_tb;
  import mpd_pkg::*;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] byte_in;
  logic byte_valid_in;
  logic byte_ready_out;
  mpd_result_t result_out;
  logic result_valid_out;
  mpd_pass_t pass_out;
  logic pass_valid_out;
  int n_errors = 0;
  int compares = 0;

  // ----------------------------------------
  // Clock, design and fetch side
  // ----------------------------------------
  always #12.5 mclk_in = ~mclk_in;

  mpd_decoder u_mpd_decoder (.mclk_in(mclk_in), .srst_in(srst_in),
    .byte_in(byte_in), .byte_valid_in(byte_valid_in),
    .byte_ready_out(byte_ready_out), .result_out(result_out),
    .result_valid_out(result_valid_out), .pass_out(pass_out),
    .pass_valid_out(pass_valid_out));

  mpd_fetch_model u_mpd_fetch_model (.mclk_in(mclk_in),
    .byte_ready_in(byte_ready_out), .byte_out(byte_in),
    .byte_valid_out(byte_valid_in));

  // ----------------------------------------
  // Shared checking
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Send up to three bytes, then check that ready is low in the hold cycle
  task automatic feed(input logic [7:0] b0, b1, b2, input int n,
                      input int gap);
    u_mpd_fetch_model.send(b0, 0);
    if (n > 1) u_mpd_fetch_model.send(b1, gap);
    if (n > 2) u_mpd_fetch_model.send(b2, 0);
    u_mpd_fetch_model.idle();
    #1;
    chk("ready_hold", 16'(byte_ready_out), 16'h0000);
  endtask

  task automatic dec(input logic [7:0] b0, b1, b2, input int n,
    input int gap, input mpd_form_t form, input logic [4:0] ca, cb);
    logic [7:0] m;
    m = (n == 3) ? b2 : ((n == 2) ? b1 : {2'h3, 3'h0, b0[2:0]});
    feed(b0, b1, b2, n, gap);
    chk("result_valid", 16'(result_valid_out), 16'h0001);
    chk("form", 16'(result_out.form), 16'(form));
    chk("clocks_a", 16'(result_out.clocks_a), 16'(ca));
    chk("clocks_b", 16'(result_out.clocks_b), 16'(cb));
    chk("mem_src", 16'(result_out.mem_src), 16'(m[7:6] != 2'h3));
    chk("mod", 16'(result_out.mod_field), 16'(m[7:6]));
    chk("rm", 16'(result_out.rm_field), 16'(m[2:0]));
    chk("reg", 16'(result_out.reg_field), 16'(m[5:3]));
    chk("src_word", 16'(result_out.src_word),
        16'((n == 3) ? b1[0] : (n == 1)));
    @(negedge mclk_in);
    #1;
    chk("ready_back", 16'(byte_ready_out), 16'h0001);
    chk("result_end", 16'(result_valid_out), 16'h0000);
  endtask

  task automatic pas(input logic [7:0] b0, b1, input int n);
    feed(b0, b1, 8'h00, n, 0);
    chk("pass_valid", 16'(pass_valid_out), 16'h0001);
    chk("result_none", 16'(result_valid_out), 16'h0000);
    chk("byte0", 16'(pass_out.byte0), 16'(b0));
    chk("two_bytes", 16'(pass_out.two_bytes), 16'(n == 2));
    if (n == 2) chk("byte1", 16'(pass_out.byte1), 16'(b1));
    @(negedge mclk_in);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Register and memory sources, one with a slow addressing byte
  task automatic t_to_seg();
    dec(8'h8E, 8'hC8, 8'h00, 2, 0, MPD_FORM_TO_SEG, 5'h02, 5'h12);
    dec(8'h8E, 8'h1D, 8'h00, 2, 3, MPD_FORM_TO_SEG, 5'h05, 5'h13);
  endtask

  task automatic t_from_seg();
    dec(8'h8C, 8'hE3, 8'h00, 2, 0, MPD_FORM_FROM_SEG, 5'h02, 5'h02);
    dec(8'h8C, 8'h58, 8'h00, 2, 0, MPD_FORM_FROM_SEG, 5'h02, 5'h02);
  endtask

  // Both widths of each extending form, register and memory
  task automatic t_extend();
    dec(8'h0F, 8'hBE, 8'hC1, 3, 0, MPD_FORM_SX, 5'h03, 5'h03);
    dec(8'h0F, 8'hBF, 8'h46, 3, 2, MPD_FORM_SX, 5'h06, 5'h06);
    dec(8'h0F, 8'hB6, 8'hFA, 3, 0, MPD_FORM_ZX, 5'h03, 5'h03);
    dec(8'h0F, 8'hB7, 8'h8C, 3, 0, MPD_FORM_ZX, 5'h06, 5'h06);
  endtask

  task automatic t_push_rm();
    dec(8'hFF, 8'h35, 8'h00, 2, 0, MPD_FORM_PUSH_RM, 5'h05, 5'h05);
    dec(8'hFF, 8'hF7, 8'h00, 2, 0, MPD_FORM_PUSH_RM, 5'h05, 5'h05);
    pas(8'hFF, 8'hC0, 2);
  endtask

  // Every register of the short form
  task automatic t_push_short();
    int r;
    for (r = 0; r < 8; r++) begin
      dec(8'h50 | 8'(r), 8'h00, 8'h00, 1, 0, MPD_FORM_PUSH_REG,
          5'h02, 5'h02);
    end
  endtask

  // Unknown single byte, unknown escape pair, near misses of patterns
  task automatic t_unknown();
    pas(8'h90, 8'h00, 1);
    pas(8'h8D, 8'h00, 1);
    pas(8'h0F, 8'h05, 2);
    pas(8'h0F, 8'hBC, 2);
  endtask

  // Reset in mid-sequence must drop the pending opcode byte
  task automatic t_reset_mid();
    u_mpd_fetch_model.send(8'h8E, 0);
    u_mpd_fetch_model.idle();
    srst_in = 1'b1;
    @(negedge mclk_in);
    srst_in = 1'b0;
    #1;
    chk("reset_ready", 16'(byte_ready_out), 16'h0001);
    chk("reset_form", 16'(result_out.form), 16'h0000);
    chk("reset_pass", 16'(pass_out.byte0), 16'h0000);
    dec(8'h53, 8'h00, 8'h00, 1, 0, MPD_FORM_PUSH_REG, 5'h02, 5'h02);
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (16) @(negedge mclk_in);
    srst_in = 1'b0;
    t_to_seg();
    t_from_seg();
    t_extend();
    t_push_rm();
    t_push_short();
    t_unknown();
    t_reset_mid();
    end_of_test();
  end
endmodule
`default_nettype wire
